// File: verilog/serial_flash_command_set.sv
// How it works
// - Array reads FFh, status 00h when delivered
// - 06 sets, 04 clears write latch
// - 9F ident, 05 status read, 01 status write
// - 03 normal read, 0B fast read
// - 02 programs bytes into one page
// - 20 wipes the one byte at its address
// - 52 and D8 both wipe the whole array, like 60 and C7
// - 60 and C7 both wipe whole chip
// - B9 enters deep sleep, AB leaves
// - AB wakes, then streams one-byte signature
// - 90 address 00 maker first, 01 device first
// - Serial input ignored while paused
module serial_flash_command_set #(
  parameter int STAT_WRITE_CYCLES = flash_cmd_pkg::STAT_WRITE_CYC
) (
  input  wire logic clk,       // 20 MHz system clock
  input  wire logic rst_n,     // Async reset, low
  input  wire logic ce,        // Clock enable
  input  wire logic cs_n,      // Chip select pin, low
  input  wire logic sclk,      // Serial clock pin
  input  wire logic si,        // Serial data in pin
  input  wire logic pause_n,   // Pause pin, low
  output logic      so,        // Serial data out
  output logic      so_oe,     // Data out enable
  output logic      sleeping,  // Deep sleep state
  output logic      busy       // Internal cycle running
);
  import flash_cmd_pkg::*;

  typedef struct packed {
    logic [2:0]  cs_s;
    logic [2:0]  ck_s;
    logic [1:0]  si_s;
    logic [1:0]  ps_s;
    logic [7:0]  sh;
    logic [2:0]  bits;
    logic [7:0]  op;
    phase_t      ph;
    logic [1:0]  nbytes;
    logic [15:0] addr;
    logic [7:0]  status;
    logic [7:0]  outb;
    logic        so;
    logic        so_oe;
    logic        sleeping;
    logic        sleep_pend;
    logic [7:0]  sleep_cnt;
    logic [8:0]  pwr_cnt;
    logic        armed;
    logic [31:0] busy_cnt;
    logic [7:0]  pend_status;
    logic        pend_sw;
    logic [1:0]  pend_wipe;
    logic        pend_pw;
    logic [7:0]  wipe_base;
    logic [1:0]  id_idx;
  } state_t;

  state_t st;
  state_t next_st;
  logic [MEM_DEPTH-1:0][7:0] mem;
  logic [MEM_DEPTH-1:0]      mem_we;

  byte_stream_if wq_in ();
  byte_stream_if wq_out ();

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (ce && !st.pend_pw && st.ph == ST_OPCODE),
    .in_s  (wq_in),
    .out_s (wq_out)
  );

  // ---------------------------------------------------------------
  // Pin sampling edges
  // ---------------------------------------------------------------
  logic sel;
  logic rise;
  logic fall;
  logic desel;
  logic live;
  logic byte_done;
  logic [7:0] rx;
  assign sel   = !st.cs_s[1];
  assign rise  = st.ck_s[1] && !st.ck_s[2] && sel;
  assign fall  = !st.ck_s[1] && st.ck_s[2] && sel;
  assign desel = st.cs_s[1] && !st.cs_s[2];
  assign live  = st.ps_s[1] && st.armed;
  assign rx    = {st.sh[6:0], st.si_s[1]};
  assign byte_done = rise && live && st.bits == BIT_LAST;

  function automatic logic known_op(input logic [7:0] o);
    case (o)
      OP_LATCH_SET, OP_LATCH_CLR, OP_STD_IDENT, OP_STAT_READ,
      OP_STAT_WRITE, OP_READ, OP_FAST_READ, OP_PAGE_WRITE,
      OP_SECT_WIPE, OP_BLK_WIPE_A, OP_BLK_WIPE_B, OP_CHIP_WIPE_A,
      OP_CHIP_WIPE_B, OP_DEEP_SLEEP, OP_WAKE, OP_MAKER_DEV:
        known_op = 1'b1;
      default: known_op = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] ident_byte(input logic [7:0] o,
                                            input logic [15:0] a,
                                            input logic [1:0] i);
    case (o)
      OP_STD_IDENT:
        ident_byte = (i == 2'h0) ? MAKER_CODE :
                     (i == 2'h1) ? MEM_TYPE : DEVICE_CODE;
      OP_MAKER_DEV:
        ident_byte = (a[0] ^ i[0]) ? DEVICE_CODE : MAKER_CODE;
      default: ident_byte = SIGNATURE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Array write port, one byte per cycle
  // ---------------------------------------------------------------
  assign wq_in.valid = byte_done && st.ph == ST_DATA
                       && st.op == OP_PAGE_WRITE;
  assign wq_in.data  = rx;
  assign wq_out.ready = ce && st.pend_pw && st.ph == ST_OPCODE;

  genvar g;
  generate
    for (g = 0; g < MEM_DEPTH; g++) begin : g_mem
      always_comb begin
        mem_we[g] = 1'b0;
        if (st.pend_wipe != 2'h0 && st.busy_cnt == 32'h1)
          mem_we[g] = (st.pend_wipe == 2'h3) ||
                      (8'(g) == st.wipe_base);
        else if (wq_out.valid && wq_out.ready)
          mem_we[g] = (8'(g) == st.addr[7:0]);
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          mem[g] <= ERASED_BYTE;
        else if (ce && mem_we[g])
          mem[g] <= (st.pend_wipe != 2'h0) ? ERASED_BYTE
                    : (mem[g] & wq_out.data);
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cs_s = {st.cs_s[1:0], cs_n};
    next_st.ck_s = {st.ck_s[1:0], sclk};
    next_st.si_s = {st.si_s[0], si};
    next_st.ps_s = {st.ps_s[0], pause_n};

    if (!st.armed) begin
      next_st.pwr_cnt = 9'(st.pwr_cnt + 1'b1);
      if (st.pwr_cnt == 9'(SELECT_DELAY_CYC - 1) && st.cs_s[1])
        next_st.armed = 1'b1;
    end

    if (wq_out.valid && wq_out.ready)
      next_st.addr = {st.addr[15:8], 8'(st.addr[7:0] + 1'b1)};
    else if (st.pend_pw && !wq_out.valid && st.ph == ST_OPCODE)
      next_st.pend_pw = 1'b0;

    if (st.busy_cnt != 32'h0) begin
      next_st.busy_cnt = st.busy_cnt - 32'h1;
      if (st.busy_cnt == 32'h1) begin
        next_st.status[SR_WIP] = 1'b0;
        next_st.status[SR_WEL] = 1'b0;
        next_st.pend_wipe = 2'h0;
        if (st.pend_sw)
          next_st.status = st.pend_status & SR_WRITABLE;
        next_st.pend_sw = 1'b0;
      end
    end

    if (st.sleep_pend) begin
      next_st.sleep_cnt = 8'(st.sleep_cnt + 1'b1);
      if (st.sleep_cnt == 8'(SLEEP_ENTRY_CYC - 1)) begin
        next_st.sleeping   = 1'b1;
        next_st.sleep_pend = 1'b0;
      end
    end

    if (fall && live && st.ph == ST_OUT) begin
      next_st.so_oe = 1'b1;
      next_st.so    = st.outb[7];
      next_st.outb  = {st.outb[6:0], 1'b0};
    end

    if (rise && live) begin
      next_st.sh   = rx;
      next_st.bits = 3'(st.bits + 1'b1);
    end

    if (byte_done) begin
      next_st.nbytes = 2'(st.nbytes + 1'b1);
      case (st.ph)
        ST_OPCODE: begin
          next_st.op     = rx;
          next_st.nbytes = 2'h0;
          next_st.id_idx = 2'h0;
          if (st.sleeping && rx != OP_WAKE)
            next_st.ph = ST_IGNORE;
          else if (!known_op(rx))
            next_st.ph = ST_IGNORE;
          else if (st.status[SR_WIP] && rx != OP_STAT_READ)
            next_st.ph = ST_IGNORE;
          else begin
            case (rx)
              OP_STAT_READ: begin
                next_st.ph   = ST_OUT;
                next_st.outb = st.status;
              end
              OP_STD_IDENT: begin
                next_st.ph     = ST_OUT;
                next_st.outb   = MAKER_CODE;
                next_st.id_idx = 2'h1;
              end
              OP_WAKE: begin
                next_st.sleeping   = 1'b0;
                next_st.sleep_pend = 1'b0;
                next_st.ph         = ST_DUMMY;
              end
              OP_READ, OP_FAST_READ, OP_PAGE_WRITE, OP_SECT_WIPE,
              OP_BLK_WIPE_A, OP_BLK_WIPE_B, OP_MAKER_DEV:
                next_st.ph = ST_ADDR;
              OP_STAT_WRITE: next_st.ph = ST_DATA;
              default:       next_st.ph = ST_WAIT;
            endcase
          end
        end
        ST_ADDR: begin
          next_st.addr = {st.addr[7:0], rx};
          if (st.nbytes == ADDR_BYTES - 2'h1) begin
            next_st.nbytes = 2'h0;
            if (st.op == OP_READ) begin
              next_st.ph   = ST_OUT;
              next_st.outb = mem[rx];
              next_st.addr = {st.addr[7:0], 8'(rx + 1'b1)};
            end else if (st.op == OP_PAGE_WRITE)
              next_st.ph = ST_DATA;
            else if (st.op == OP_FAST_READ || st.op == OP_MAKER_DEV)
              next_st.ph = ST_DUMMY;
            else
              next_st.ph = ST_WAIT;
          end
        end
        ST_DUMMY: begin
          next_st.ph = ST_OUT;
          if (st.op == OP_FAST_READ) begin
            next_st.outb = mem[st.addr[7:0]];
            next_st.addr = {st.addr[15:8], 8'(st.addr[7:0] + 1'b1)};
          end else begin
            next_st.outb   = ident_byte(st.op, st.addr, 2'h0);
            next_st.id_idx = 2'h1;
          end
        end
        ST_DATA: begin
          next_st.pend_status = rx;
          if (st.op == OP_PAGE_WRITE)
            next_st.pend_pw = 1'b1;
        end
        ST_OUT: begin
          if (st.op == OP_READ || st.op == OP_FAST_READ) begin
            next_st.outb = mem[st.addr[7:0]];
            next_st.addr = {st.addr[15:8], 8'(st.addr[7:0] + 1'b1)};
          end else if (st.op == OP_STAT_READ)
            next_st.outb = st.status;
          else begin
            next_st.outb   = ident_byte(st.op, st.addr, st.id_idx);
            next_st.id_idx = (st.id_idx == IDENT_BYTES - 2'h1)
                             ? 2'h0 : 2'(st.id_idx + 1'b1);
          end
        end
        default: ;
      endcase
    end

    if (desel) begin
      next_st.ph    = ST_OPCODE;
      next_st.bits  = 3'h0;
      next_st.so_oe = 1'b0;
      if (st.bits == 3'h0 && st.ph != ST_IGNORE) begin
        case (st.op)
          OP_LATCH_SET:
            if (st.ph == ST_WAIT) next_st.status[SR_WEL] = 1'b1;
          OP_LATCH_CLR:
            if (st.ph == ST_WAIT) next_st.status[SR_WEL] = 1'b0;
          OP_DEEP_SLEEP:
            if (st.ph == ST_WAIT) begin
              next_st.sleep_pend = 1'b1;
              next_st.sleep_cnt  = 8'h0;
            end
          OP_STAT_WRITE:
            if (st.ph == ST_DATA && st.nbytes == 2'h1 &&
                st.status[SR_WEL]) begin
              next_st.pend_sw        = 1'b1;
              next_st.busy_cnt       = 32'(STAT_WRITE_CYCLES);
              next_st.status[SR_WIP] = 1'b1;
            end
          OP_SECT_WIPE, OP_BLK_WIPE_A, OP_BLK_WIPE_B,
          OP_CHIP_WIPE_A, OP_CHIP_WIPE_B:
            if (st.ph == ST_WAIT && st.status[SR_WEL]) begin
              next_st.pend_wipe = (st.op == OP_CHIP_WIPE_A ||
                                   st.op == OP_CHIP_WIPE_B ||
                                   st.op == OP_BLK_WIPE_A ||
                                   st.op == OP_BLK_WIPE_B)
                                  ? 2'h3 : 2'h1;
              next_st.wipe_base      = st.addr[7:0];
              next_st.busy_cnt       = 32'h2;
              next_st.status[SR_WIP] = 1'b1;
            end
          OP_PAGE_WRITE:
            if (st.status[SR_WEL]) next_st.status[SR_WEL] = 1'b0;
          default: ;
        endcase
      end
    end
    if (st.cs_s[1]) next_st.so_oe = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.cs_s   <= 3'h7;
      st.ps_s   <= 2'h3;
      st.ph     <= ST_OPCODE;
      st.status <= STATUS_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign so       = st.so;
  assign so_oe    = st.so_oe;
  assign sleeping = st.sleeping;
  assign busy     = st.status[SR_WIP];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reset_status: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> st.status == STATUS_RESET)
    else $error("status not clear after reset");
  a_unknown_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && byte_done && st.ph == ST_OPCODE && !known_op(rx))
    |=> st.ph == ST_IGNORE)
    else $error("unknown opcode not ignored");
  a_pause_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !st.ps_s[1]) |-> next_st.sh == st.sh)
    else $error("input shifted while paused");
  a_wake_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && byte_done && st.ph == ST_OPCODE && rx == OP_WAKE)
    |=> !st.sleeping)
    else $error("wake did not leave sleep");
  a_latch_set: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && desel && st.ph == ST_WAIT && st.bits == 3'h0 &&
     st.op == OP_LATCH_SET) |=> st.status[SR_WEL])
    else $error("write latch not set");
  a_chip_wipe: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && st.pend_wipe == 2'h3 && st.busy_cnt == 32'h1)
    |=> mem[0] == ERASED_BYTE)
    else $error("whole wipe left data");
endmodule

// File: verilog/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR   = 8'h04;
  localparam logic [7:0] OP_STD_IDENT   = 8'h9f;
  localparam logic [7:0] OP_STAT_READ   = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;
  localparam logic [7:0] OP_PAGE_WRITE  = 8'h02;
  localparam logic [7:0] OP_SECT_WIPE   = 8'h20;
  localparam logic [7:0] OP_BLK_WIPE_A  = 8'h52;
  localparam logic [7:0] OP_BLK_WIPE_B  = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hc7;
  localparam logic [7:0] OP_DEEP_SLEEP  = 8'hb9;
  localparam logic [7:0] OP_WAKE        = 8'hab;
  localparam logic [7:0] OP_MAKER_DEV   = 8'h90;

  // ---------------------------------------------------------------
  // Values and identity (identity values are arbitrary)
  // ---------------------------------------------------------------
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] MAKER_CODE     = 8'h5a;
  localparam logic [7:0] DEVICE_CODE    = 8'h3c;
  localparam logic [7:0] MEM_TYPE       = 8'h21;
  localparam logic [7:0] SIGNATURE      = 8'h3c;
  localparam int         ADDR_W         = 8;
  localparam int         MEM_DEPTH      = 256;
  localparam int         FIFO_DEPTH     = 8;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] ADDR_BYTES     = 2'h3;
  localparam logic [1:0] IDENT_BYTES    = 2'h3;
  localparam int         SR_WIP         = 0;
  localparam int         SR_WEL         = 1;
  localparam logic [7:0] SR_WRITABLE    = 8'h8c;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 20;
  localparam int SELECT_DELAY_US  = 10;
  localparam int SELECT_DELAY_CYC = SELECT_DELAY_US * CLK_MHZ;
  localparam int STAT_WRITE_MS    = 15;
  localparam int STAT_WRITE_CYC   = STAT_WRITE_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_ENTRY_US   = 3;
  localparam int SLEEP_ENTRY_CYC  = SLEEP_ENTRY_US * CLK_MHZ;

  typedef enum logic [6:0] {
    ST_OPCODE = 7'h01,
    ST_ADDR   = 7'h02,
    ST_DUMMY  = 7'h04,
    ST_DATA   = 7'h08,
    ST_OUT    = 7'h10,
    ST_IGNORE = 7'h20,
    ST_WAIT   = 7'h40
  } phase_t;
endpackage

// File: verilog/byte_stream_if.sv
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// File: verilog/byte_fifo.sv
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk,    // System clock
  input  wire logic rst_n,  // Async reset, low
  input  wire logic clr,    // Synchronous flush
  byte_stream_if.dst in_s,  // Filling side
  byte_stream_if.src out_s  // Draining side
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } fifo_t;

  fifo_t st;
  fifo_t next_st;
  logic  push;
  logic  pop;

  assign in_s.ready  = (st.cnt != (PW+1)'(DEPTH));
  assign out_s.valid = (st.cnt != '0);
  assign out_s.data  = st.mem[st.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  always_comb begin
    next_st = st;
    if (clr) begin
      next_st.wr  = '0;
      next_st.rd  = '0;
      next_st.cnt = '0;
    end else begin
      if (push) begin
        next_st.mem[st.wr] = in_s.data;
        next_st.wr = PW'(st.wr + 1'b1);
      end
      if (pop)
        next_st.rd = PW'(st.rd + 1'b1);
      next_st.cnt = (PW+1)'(st.cnt + push - pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// File: test/spi_host_model.sv
module spi_host_model
  import flash_cmd_pkg::*;
(
  input  wire logic clk,     // System clock
  input  wire logic rst_n,   // Async reset, low
  input  wire logic so,      // Device serial out
  output logic      cs_n,    // Chip select, low
  output logic      sclk,    // Serial clock, idles low
  output logic      si,      // Serial data to device
  output logic      pause_n  // Pause, low
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n    = 1'b1;
    sclk    = 1'b0;
    si      = 1'b0;
    pause_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Select held off after every reset release
  task automatic power_wait();
    wait (rst_n === 1'b1);
    tick(SELECT_DELAY_CYC + 5);
  endtask

  task automatic select();
    tick(1);
    cs_n <= 1'b0;
    tick(6);
  endtask

  // Released data line shows the inverse of its last level
  task automatic deselect();
    tick(6);
    cs_n <= 1'b1;
    si   <= ~si;
    tick(6);
  endtask

  task automatic hold(input logic v);
    pause_n <= v;
    tick(3);
  endtask

  task automatic bitx(input logic b, output logic r);
    si <= b;
    tick(6);
    @(negedge clk);
    r = so;
    @(posedge clk);
    sclk <= 1'b1;
    tick(6);
    sclk <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], r);
      rx[i] = r;
    end
  endtask
endmodule

// File: test/testbench.sv
module testbench
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int SW_CYC = 20;
  localparam int LIMIT  = 80000;

  typedef struct {
    logic [47:0] tx;
    int          ntx;
    int          nrx;
    logic [15:0] exp;
  } row_t;

  logic        clk        = 1'b0;
  logic        rst_n      = 1'b0;
  logic        ce         = 1'b1;
  logic        cs_n;
  logic        sclk;
  logic        si;
  logic        pause_n;
  logic        so;
  logic        so_oe;
  logic        sleeping;
  logic        busy;
  logic        b;
  logic [15:0] rx;
  logic [7:0]  s;
  logic [7:0]  e;
  logic [7:0]  w;
  int          nw;
  int          fails      = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  row_t        rows [6];
  logic [7:0]  wipes [5];

  always #25 clk = ~clk;

  serial_flash_command_set #(.STAT_WRITE_CYCLES(SW_CYC))
    serial_flash_command_set_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .cs_n(cs_n), .sclk(sclk), .si(si), .pause_n(pause_n), .so(so),
    .so_oe(so_oe), .sleeping(sleeping), .busy(busy));

  spi_host_model spi_host_model_i (.clk(clk), .rst_n(rst_n), .so(so),
    .cs_n(cs_n), .sclk(sclk), .si(si), .pause_n(pause_n));

  // ---------------------------------------------------------------
  // Checking and bus helpers
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp,
                        input logic got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic cmd(input logic [47:0] tx, input int ntx, input int nrx);
    logic [7:0] d;
    rx = 16'h0000;
    spi_host_model_i.select();
    for (int i = 0; i < ntx; i++)
      spi_host_model_i.xfer(tx[47-8*i -: 8], d);
    for (int i = 0; i < nrx; i++) begin
      spi_host_model_i.xfer(8'h00, d);
      rx = {rx[7:0], d};
    end
    spi_host_model_i.deselect();
  endtask

  task automatic op(input logic [7:0] code);
    cmd({code, 40'h0}, 1, 0);
  endtask

  task automatic stat();
    cmd({OP_STAT_READ, 40'h0}, 1, 1);
    s = rx[7:0];
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check1("busy", 1'b0, busy);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("timeout after %0d cycles", cycles);
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{
      '{{OP_STAT_READ, 40'h0}, 1, 1, {8'h00, STATUS_RESET}},
      '{{OP_READ, 24'h10, 16'h0}, 4, 2, {2{ERASED_BYTE}}},
      '{{OP_FAST_READ, 24'h10, 16'h0}, 5, 2, {2{ERASED_BYTE}}},
      '{{OP_MAKER_DEV, 24'h0, 16'h0}, 5, 2, {MAKER_CODE, DEVICE_CODE}},
      '{{OP_MAKER_DEV, 24'h1, 16'h0}, 5, 2, {DEVICE_CODE, MAKER_CODE}},
      '{{OP_STD_IDENT, 40'h0}, 1, 1, {8'h00, MAKER_CODE}}};
    wipes = '{OP_SECT_WIPE, OP_BLK_WIPE_A, OP_BLK_WIPE_B,
              OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    spi_host_model_i.power_wait();
    foreach (rows[r]) begin
      cmd(rows[r].tx, rows[r].ntx, rows[r].nrx);
      for (int k = 0; k < rows[r].nrx; k++) begin
        e = rows[r].exp[8*k +: 8];
        s = rx[8*k +: 8];
        check8("read byte", e, s);
      end
    end
    done("table");
    op(OP_LATCH_SET);
    stat();
    check8("status", 8'h02, s);
    op(OP_LATCH_CLR);
    stat();
    check8("status", 8'h00, s);
    done("write latch");
    op(OP_LATCH_SET);
    cmd({OP_STAT_WRITE, 8'hff, 32'h0}, 2, 0);
    check1("busy", 1'b1, busy);
    wait_idle(SW_CYC + 40);
    stat();
    check8("status", SR_WRITABLE, s & SR_WRITABLE);
    op(OP_LATCH_SET);
    cmd({OP_STAT_WRITE, 8'h00, 32'h0}, 2, 0);
    wait_idle(SW_CYC + 40);
    stat();
    check8("status", 8'h00, s & SR_WRITABLE);
    done("status write");
    foreach (wipes[i]) begin
      w = wipes[i];
      op(OP_LATCH_SET);
      cmd({OP_PAGE_WRITE, 24'h20, 8'ha5, 8'h5a}, 6, 0);
      wait_idle(2000);
      cmd({OP_READ, 24'h20, 16'h0}, 4, 2);
      check8("page hi", 8'ha5, rx[15:8]);
      check8("page lo", 8'h5a, rx[7:0]);
      nw = (w === OP_CHIP_WIPE_A || w === OP_CHIP_WIPE_B) ? 1 : 4;
      op(OP_LATCH_SET);
      cmd({w, 24'h20, 16'h0}, nw, 0);
      wait_idle(2000);
      cmd({OP_READ, 24'h20, 16'h0}, 4, 2);
      check8("wiped hi", ERASED_BYTE, rx[15:8]);
      e = (w === OP_SECT_WIPE) ? 8'h5a : ERASED_BYTE;
      check8("wiped lo", e, rx[7:0]);
    end
    done("program and wipe");
    op(OP_LATCH_SET);
    cmd({8'h33, OP_STAT_WRITE, 8'hff, 24'h0}, 3, 0);
    stat();
    check8("status", 8'h02, s);
    op(OP_LATCH_CLR);
    done("unknown opcode");
    spi_host_model_i.select();
    for (int i = 7; i >= 4; i--)
      spi_host_model_i.bitx(OP_STAT_READ[i], b);
    spi_host_model_i.hold(1'b0);
    repeat (8) spi_host_model_i.bitx(1'b1, b);
    spi_host_model_i.hold(1'b1);
    for (int i = 3; i >= 0; i--)
      spi_host_model_i.bitx(OP_STAT_READ[i], b);
    spi_host_model_i.xfer(8'h00, s);
    check8("status", 8'h00, s);
    check1("so_oe", 1'b1, so_oe);
    spi_host_model_i.deselect();
    done("pause");
    op(OP_DEEP_SLEEP);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge clk);
    check1("sleeping", 1'b1, sleeping);
    op(OP_LATCH_SET);
    check1("sleeping", 1'b1, sleeping);
    cmd({OP_WAKE, 40'h0}, 2, 1);
    check8("signature", SIGNATURE, rx[7:0]);
    check1("sleeping", 1'b0, sleeping);
    stat();
    check8("status", 8'h00, s);
    op(OP_DEEP_SLEEP);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge clk);
    op(OP_WAKE);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge clk);
    check1("sleeping", 1'b0, sleeping);
    done("deep sleep");
    op(OP_LATCH_SET);
    cmd({OP_PAGE_WRITE, 24'h40, 8'ha5, 8'h5a}, 6, 0);
    wait_idle(2000);
    op(OP_DEEP_SLEEP);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check1("sleeping", 1'b0, sleeping);
    check1("so_oe", 1'b0, so_oe);
    rst_n <= 1'b1;
    spi_host_model_i.power_wait();
    cmd({OP_READ, 24'h40, 16'h0}, 4, 2);
    check8("array", ERASED_BYTE, rx[15:8]);
    stat();
    check8("status", STATUS_RESET, s);
    done("reset");
    end_sim();
  end
endmodule
